// ### bench/adres_status_properties.sv
// Checker for adres_status: APB answer timing, control and interrupt outputs.
// Bound to every adres_status instance; sees only its ports.
`timescale 1ns/100ps
module adres_status_props (
	input wire logic        i_core_clk,
	input wire logic        i_rst_b,
	input wire logic        i_clk_en,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic        i_store_valid,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_module_enable,
	input wire logic        o_store_on_abort,
	input wire logic        o_conv_irq
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	// Access phase still owed its single wait state
	sequence s_wait;
		i_psel && i_penable && !o_pready && i_clk_en;
	endsequence
	// Write that completes at this edge
	sequence s_wdone;
		i_psel && i_penable && i_pwrite && o_pready;
	endsequence
	pready_wait_a: assert property (s_wait |=> o_pready)
		else $error("access not answered after one wait state");
	pready_pulse_a: assert property (o_pready && i_clk_en |=> !o_pready)
		else $error("pready held longer than one cycle");
	pready_cause_a: assert property (!(i_psel && i_penable) && i_clk_en |=> !o_pready)
		else $error("pready without an access phase");
	slverr_ready_a: assert property (o_pslverr |-> o_pready)
		else $error("pslverr outside a completion");
	wr_data_zero_a: assert property (s_wdone |-> o_prdata == 32'h0)
		else $error("read data not zero on a write");
	irq_off_a: assert property (!o_module_enable [*2] |-> !o_conv_irq)
		else $error("interrupt while disabled");
	irq_cause_a: assert property ($rose(o_conv_irq) |->
		$past(i_store_valid) || $past(i_psel && i_penable && i_pwrite))
		else $error("interrupt rose with no store or enable write");
	ctrl_write_a: assert property ($changed({o_module_enable, o_store_on_abort}) |->
		$past(i_psel && i_penable && i_pwrite && o_pready))
		else $error("control output changed without a write");
endmodule // adres_status_props

bind adres_status adres_status_props u_props (
	.i_core_clk       (i_core_clk),
	.i_rst_b          (i_rst_b),
	.i_clk_en         (i_clk_en),
	.i_psel           (i_psel),
	.i_penable        (i_penable),
	.i_pwrite         (i_pwrite),
	.i_store_valid    (i_store_valid),
	.o_prdata         (o_prdata),
	.o_pready         (o_pready),
	.o_pslverr        (o_pslverr),
	.o_module_enable  (o_module_enable),
	.o_store_on_abort (o_store_on_abort),
	.o_conv_irq       (o_conv_irq)
);

// ### bench/tb.sv
// Testbench for adres_status: APB master and sequencer event pulses.
// Assumes adres_consts.vh on the include path; no partner model.
`timescale 1ns/100ps
`include "adres_consts.vh"
module tb;
	logic        i_core_clk = '0, i_rst_b = '0, i_clk_en = '1, i_psel = '0, i_penable = '0;
	logic        i_pwrite = '0, i_store_valid = '0, i_store_end_list = '0, i_store_first = '0;
	logic        i_command_list = '0, i_result_buffer_list = '0, i_double_buffer = '0;
	logic        i_abort_sw = '0, i_abort_hw = '0, i_abort_conv_busy = '0, serr;
	logic [3:0]  i_store_flag_sel = '0;
	logic [5:0]  i_store_index = '0, i_abort_index = '0;
	logic [7:0]  i_paddr = '0;
	logic [31:0] i_pwdata = '0, rdat;
	wire  [31:0] o_prdata;
	wire         o_pready, o_pslverr, o_module_enable, o_store_on_abort, o_conv_irq;
	int          err_count = 0, n_tests = 0;
	localparam [7:0] ctl = `ADRES_OFF_CTRL, ien = `ADRES_OFF_IRQ_EN, cfl = `ADRES_OFF_CONV_FLG;
	localparam [7:0] mid = `ADRES_OFF_MID_INFO, eli = `ADRES_OFF_END_INFO, msc = `ADRES_OFF_MISC_FLG;

	adres_status uut (
		.i_core_clk           (i_core_clk),
		.i_rst_b              (i_rst_b),
		.i_clk_en             (i_clk_en),
		.i_psel               (i_psel),
		.i_penable            (i_penable),
		.i_pwrite             (i_pwrite),
		.i_paddr              (i_paddr),
		.i_pwdata             (i_pwdata),
		.o_prdata             (o_prdata),
		.o_pready             (o_pready),
		.o_pslverr            (o_pslverr),
		.i_store_valid        (i_store_valid),
		.i_store_flag_sel     (i_store_flag_sel),
		.i_store_end_list     (i_store_end_list),
		.i_store_first        (i_store_first),
		.i_store_index        (i_store_index),
		.i_command_list       (i_command_list),
		.i_result_buffer_list (i_result_buffer_list),
		.i_double_buffer      (i_double_buffer),
		.i_abort_sw           (i_abort_sw),
		.i_abort_hw           (i_abort_hw),
		.i_abort_conv_busy    (i_abort_conv_busy),
		.i_abort_index        (i_abort_index),
		.o_module_enable      (o_module_enable),
		.o_store_on_abort     (o_store_on_abort),
		.o_conv_irq           (o_conv_irq)
	);

	// Core clock, 100 MHz
	always #5 i_core_clk = ~i_core_clk;

	task end_of_test;
		$display("tests=%0d errors=%0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One transfer; request held until pready seen, then an idle cycle
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_core_clk);
		i_penable <= 1'b1;
		k = 0;
		do begin
			@(posedge i_core_clk);
			k++;
		end while (o_pready !== 1'b1 && k < 20);
		if (o_pready !== 1'b1) chk({31'h0, o_pready}, 32'h1); // Timeout is a mismatch
		rdat = o_prdata;
		serr = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_core_clk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask

	task irq(input logic e);
		chk({31'h0, o_conv_irq}, {31'h0, e});
	endtask

	// One stored result pulse from the sequencer
	task store(input logic [3:0] s, input logic e, input logic [5:0] x);
		i_store_valid <= 1'b1;
		i_store_flag_sel <= s;
		i_store_end_list <= e;
		i_store_index <= x;
		@(posedge i_core_clk);
		i_store_valid <= 1'b0;
		@(posedge i_core_clk);
	endtask

	// Executed abort pulse, software or hardware
	task ab(input logic s, input logic b, input logic [5:0] x);
		i_abort_sw <= s;
		i_abort_hw <= !s;
		i_abort_conv_busy <= b;
		i_abort_index <= x;
		@(posedge i_core_clk);
		i_abort_sw <= 1'b0;
		i_abort_hw <= 1'b0;
		@(posedge i_core_clk);
	endtask

	task t_reset;
		rd(cfl, 32'h0);
		rd(mid, 32'h0);
		rd(eli, 32'h0);
		rd(8'h18, 32'h0);
		chk({31'h0, serr}, 32'h1);
		store(4'h3, 1'b0, 6'h05);
		rd(cfl, 32'h0);
	endtask

	task t_flags;
		wr(ctl, 32'h1);
		wr(ien, 32'hffff);
		store(4'h0, 1'b0, 6'h01);
		rd(cfl, 32'h0);
		for (int n = 1; n < 16; n++) begin
			i_command_list <= n[0];
			i_result_buffer_list <= n[1];
			store(n[3:0], 1'b0, n[5:0]);
			irq(1'b1);
			rd(cfl, 32'h1 << n);
			rd(mid, {16'h0, n[0], n[1], 8'h0, n[5:0]});
			wr(cfl, 32'h0);
			rd(cfl, 32'h1 << n);
			wr(cfl, 32'h1 << n);
			rd(cfl, 32'h0);
		end
		irq(1'b0);
		wr(cfl, 32'hffff);
		rd(cfl, 32'h0);
		wr(mid, 32'h0);
		rd(mid, 32'hc00f);
	endtask

	task t_eol;
		i_command_list <= 1'b1;
		i_result_buffer_list <= 1'b0;
		store(4'h0, 1'b1, 6'h09);
		rd(cfl, 32'h1);
		rd(eli, 32'h80);
		rd(mid, 32'hc009);
		irq(1'b1);
		wr(ien, 32'hfffe);
		irq(1'b0);
		wr(cfl, 32'h1);
		i_double_buffer <= 1'b1;
		store(4'h2, 1'b0, 6'h01);
		store(4'h2, 1'b0, 6'h02);
		rd(msc, 32'h40);
		wr(msc, 32'h40);
		wr(cfl, 32'h4);
		i_double_buffer <= 1'b0;
		store(4'h3, 1'b0, 6'h04);
		i_store_first <= 1'b1;
		store(4'h1, 1'b0, 6'h05);
		i_store_first <= 1'b0;
		rd(msc, 32'h40);
		wr(msc, 32'h40);
		wr(cfl, 32'ha);
	endtask

	task t_abort;
		wr(ctl, 32'h5);
		chk({30'h0, o_store_on_abort, o_module_enable}, 32'h3);
		i_command_list <= 1'b0;
		i_result_buffer_list <= 1'b1;
		ab(1'b1, 1'b1, 6'h21);
		rd(msc, 32'h80);
		rd(mid, 32'h4021);
		wr(msc, 32'h80);
		wr(ctl, 32'h1);
		chk({30'h0, o_store_on_abort, o_module_enable}, 32'h1);
		ab(1'b1, 1'b1, 6'h28);
		rd(mid, 32'h4021);
		wr(msc, 32'h80);
		store(4'h0, 1'b0, 6'h11);
		ab(1'b1, 1'b0, 6'h3c);
		rd(mid, 32'h4021);
		wr(msc, 32'h80);
		ab(1'b0, 1'b1, 6'h32);
		rd(msc, 32'h0);
		rd(mid, 32'h4011);
	endtask

	task t_srst;
		store(4'h5, 1'b0, 6'h03);
		wr(ctl, 32'h3);
		rd(cfl, 32'h0);
		rd(eli, 32'h0);
		rd(ctl, 32'h1);
		store(4'h5, 1'b0, 6'h03);
		wr(ctl, 32'h0);
		chk({30'h0, o_store_on_abort, o_module_enable}, 32'h0);
		wr(ctl, 32'h1);
		rd(cfl, 32'h0);
		rd(mid, 32'h0);
	endtask

	// Main sequence after a three cycle reset
	initial begin
		repeat (3) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		@(posedge i_core_clk);
		t_reset;
		t_flags;
		t_eol;
		t_abort;
		t_srst;
		end_of_test;
	end

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge i_core_clk);
		err_count++;
		end_of_test;
	end
endmodule // tb

// ### common/adres_consts.vh
// Constants for the result event status block: offsets, fields, resets.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef ADRES_CONSTS_VH
`define ADRES_CONSTS_VH

// Register byte offsets
`define ADRES_OFF_CTRL      8'h00
`define ADRES_OFF_IRQ_EN    8'h04
`define ADRES_OFF_CONV_FLG  8'h08
`define ADRES_OFF_MID_INFO  8'h0c
`define ADRES_OFF_END_INFO  8'h10
`define ADRES_OFF_MISC_FLG  8'h14

// Control register fields
`define ADRES_CTRL_ENABLE   0
`define ADRES_CTRL_SRST     1
`define ADRES_CTRL_STORE_AB 2

// Miscellaneous flag fields
`define ADRES_MISC_OVERRUN  6
`define ADRES_MISC_ABORT    7

// Intermediate info fields
`define ADRES_MID_LIST      15
`define ADRES_MID_BUF       14
`define ADRES_MID_IDX_HI    5

// End of list info fields
`define ADRES_END_LIST      7
`define ADRES_END_BUF       6

// Reset values
`define ADRES_CTRL_RST      3'h0
`define ADRES_FLAGS_RST     16'h0000
`define ADRES_IDX_RST       6'h00

`endif

// ### logic/adres_status.v
// Result event status registers of a list-driven converter sequencer.
// Assumes the sequencer pulses one store event per result written to RAM
// and one abort event per executed sequence abort, all on i_core_clk.
`timescale 1ns/100ps
`include "adres_consts.vh"

// Notes on behaviour
// - Writing one to a set conversion or list-end flag clears it.
// - All flags clear while enable is low or soft reset is set.
// - Writing zero to a flag leaves it as it is.
// - Software writing one never sets a flag; only hardware sets.
// - Stored command sets conversion flag chosen by its flag select field.
// - Stored end-of-list command sets list-end flag in bit 0.
// - Double buffer: setting a set flag raises overrun; single buffer: first store of a list while any conversion flag is set.
// - Both info registers clear on soft reset or disable; read only.
// - Info bit 15 captures active command list on flag or abort.
// - Info bit 14 captures active buffer list on flag or abort.
// - Info bits 5..0 capture result index on flag, list end, abort.
// - Abort of running conversion picks aborted or last stored index.
// - Processed software abort sets abort done flag, running or idle.
// - Software abort with no conversion running keeps the captured index.
// - Hardware stop or wait abort captures index without done flag.
// - Intermediate info updates in the same cycle as its flag sets.
// - End info records the command list active at list end.
// - End info bit 6 records the buffer list active at list end.
// - Flag select zero sets nothing; value n sets conversion flag n.
// - Each conversion flag and list-end flag has its own enable bit.
module adres_status (
	input  wire        i_core_clk,
	input  wire        i_rst_b,
	input  wire        i_clk_en,
	// APB slave
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [7:0]  i_paddr,
	input  wire [31:0] i_pwdata,
	output wire [31:0] o_prdata,
	output wire        o_pready,
	output wire        o_pslverr,
	// Result store event from the sequencer
	input  wire        i_store_valid,
	input  wire [3:0]  i_store_flag_sel,
	input  wire        i_store_end_list,
	input  wire        i_store_first,
	input  wire [5:0]  i_store_index,
	input  wire        i_command_list,
	input  wire        i_result_buffer_list,
	input  wire        i_double_buffer,
	// Sequence abort events
	input  wire        i_abort_sw,
	input  wire        i_abort_hw,
	input  wire        i_abort_conv_busy,
	input  wire [5:0]  i_abort_index,
	// Controls seen by the sequencer
	output wire        o_module_enable,
	output wire        o_store_on_abort,
	output wire        o_conv_irq
);

	// Bus handshake and register state
	reg        pready_q;
	reg        pready_d;
	reg        pslverr_q;
	reg        pslverr_d;
	reg [31:0] prdata_q;
	reg [31:0] prdata_d;
	reg [2:0]  ctrl_q;
	reg [2:0]  ctrl_d;
	reg [15:0] irq_en_q;
	reg [15:0] irq_en_d;
	reg [15:0] conv_flag_q;
	reg [15:0] conv_flag_d;
	reg        abort_done_q;
	reg        abort_done_d;
	reg        overrun_q;
	reg        overrun_d;
	reg        mid_list_q;
	reg        mid_list_d;
	reg        mid_buf_q;
	reg        mid_buf_d;
	reg [5:0]  mid_idx_q;
	reg [5:0]  mid_idx_d;
	reg        end_list_q;
	reg        end_list_d;
	reg        end_buf_q;
	reg        end_buf_d;
	reg [5:0]  last_idx_q;
	reg [5:0]  last_idx_d;
	reg        irq_q;
	reg        irq_d;

	// Decoded events
	wire        bus_access;
	wire        wr_fire;
	wire        clear_all;
	wire [15:0] set_vec;
	wire [15:0] w1c_conv;
	wire        w1c_misc_ab;
	wire        w1c_misc_ov;
	wire        overrun_evt;
	wire        any_abort;
	wire [15:0] sel_onehot;

	// One-hot decode of the flag select field; zero selects nothing
	function [15:0] adres_flag_decode;
		input [3:0] sel;
		begin
			adres_flag_decode = 16'h0000;
			if (sel != 4'h0) begin
				adres_flag_decode[sel] = 1'b1;
			end
		end
	endfunction

	// Address match helper, shared by read and write paths
	// Only word addresses compare; bits 1:0 of the address are ignored
	function adres_hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			adres_hit = (addr[7:2] == off[7:2]);
		end
	endfunction

	function adres_mapped;
		input [7:0] addr;
		begin
			adres_mapped = adres_hit(addr, `ADRES_OFF_CTRL)
				| adres_hit(addr, `ADRES_OFF_IRQ_EN)
				| adres_hit(addr, `ADRES_OFF_CONV_FLG)
				| adres_hit(addr, `ADRES_OFF_MID_INFO)
				| adres_hit(addr, `ADRES_OFF_END_INFO)
				| adres_hit(addr, `ADRES_OFF_MISC_FLG);
		end
	endfunction

	// One wait state: answer comes the cycle after the access phase opens
	assign bus_access = i_psel & i_penable;
	assign wr_fire    = bus_access & pready_q & i_pwrite & adres_mapped(i_paddr);

	// Disable or soft reset wipes flags and info; takes priority over events
	assign clear_all = ~ctrl_q[`ADRES_CTRL_ENABLE]
		| ctrl_q[`ADRES_CTRL_SRST];

	// Flag select decoded once into a one-hot conversion flag position
	assign sel_onehot = adres_flag_decode(i_store_flag_sel);

	// Hardware set vector: conversion flag plus list-end flag in bit 0
	assign set_vec = i_store_valid
		? {sel_onehot[15:1], i_store_end_list}
		: 16'h0000;

	// Write-one-to-clear masks; zero bits in the data do nothing
	assign w1c_conv    = (wr_fire & adres_hit(i_paddr, `ADRES_OFF_CONV_FLG))
		? i_pwdata[15:0] : 16'h0000;
	assign w1c_misc_ab = wr_fire & adres_hit(i_paddr, `ADRES_OFF_MISC_FLG)
		& i_pwdata[`ADRES_MISC_ABORT];
	assign w1c_misc_ov = wr_fire & adres_hit(i_paddr, `ADRES_OFF_MISC_FLG)
		& i_pwdata[`ADRES_MISC_OVERRUN];

	// Overrun: double buffer checks every flag being set again;
	// single buffer only checks conversion flags at the first store of a list
	// Overrun only reports; the repeated event still sets its flag
	assign overrun_evt = i_double_buffer
		? |(set_vec & conv_flag_q)
		: (i_store_valid & i_store_first & |conv_flag_q[15:1]);

	assign any_abort = i_abort_sw | i_abort_hw;

	// APB answer path
	// Reads of write cycles or holes give zero, so stale data never leaks
	always @* begin
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		prdata_d  = prdata_q;
		if (bus_access & ~pready_q) begin
			pready_d  = 1'b1;
			pslverr_d = ~adres_mapped(i_paddr);
			prdata_d  = 32'h0000_0000;
			if (~i_pwrite) begin
				if (adres_hit(i_paddr, `ADRES_OFF_CTRL)) begin
					prdata_d[2:0] = ctrl_q;
				end
				if (adres_hit(i_paddr, `ADRES_OFF_IRQ_EN)) begin
					prdata_d[15:0] = irq_en_q;
				end
				if (adres_hit(i_paddr, `ADRES_OFF_CONV_FLG)) begin
					prdata_d[15:0] = conv_flag_q;
				end
				if (adres_hit(i_paddr, `ADRES_OFF_MID_INFO)) begin
					prdata_d[`ADRES_MID_LIST] = mid_list_q;
					prdata_d[`ADRES_MID_BUF]  = mid_buf_q;
					prdata_d[`ADRES_MID_IDX_HI:0] = mid_idx_q;
				end
				if (adres_hit(i_paddr, `ADRES_OFF_END_INFO)) begin
					prdata_d[`ADRES_END_LIST] = end_list_q;
					prdata_d[`ADRES_END_BUF]  = end_buf_q;
				end
				if (adres_hit(i_paddr, `ADRES_OFF_MISC_FLG)) begin
					prdata_d[`ADRES_MISC_ABORT]   = abort_done_q;
					prdata_d[`ADRES_MISC_OVERRUN] = overrun_q;
				end
			end
		end
	end

	// Control and enable registers; soft reset bit falls back after one cycle
	// The soft reset pulse thus clears flags and info for exactly one cycle
	always @* begin
		ctrl_d   = ctrl_q;
		irq_en_d = irq_en_q;
		ctrl_d[`ADRES_CTRL_SRST] = 1'b0;   // Self clearing so flags restart
		if (wr_fire & adres_hit(i_paddr, `ADRES_OFF_CTRL)) begin
			ctrl_d = i_pwdata[2:0];
		end
		if (wr_fire & adres_hit(i_paddr, `ADRES_OFF_IRQ_EN)) begin
			irq_en_d = i_pwdata[15:0];
		end
	end

	// Flag registers: hardware set beats software clear in the same cycle
	// Disable or soft reset still wins over any set in that cycle
	always @* begin
		conv_flag_d  = conv_flag_q;
		abort_done_d = abort_done_q;
		overrun_d    = overrun_q;
		if (clear_all) begin
			conv_flag_d  = `ADRES_FLAGS_RST;
			abort_done_d = 1'b0;
			overrun_d    = 1'b0;
		end else begin
			// Only the hardware vector ORs in; write data never sets
			conv_flag_d  = (conv_flag_q & ~w1c_conv) | set_vec;
			abort_done_d = (abort_done_q & ~w1c_misc_ab) | i_abort_sw;
			overrun_d    = (overrun_q & ~w1c_misc_ov) | overrun_evt;
		end
	end

	// Intermediate and end-of-list information capture
	// Trade-off: a store in the same cycle as an abort loses its index
	always @* begin
		mid_list_d = mid_list_q;
		mid_buf_d  = mid_buf_q;
		mid_idx_d  = mid_idx_q;
		end_list_d = end_list_q;
		end_buf_d  = end_buf_q;
		last_idx_d = last_idx_q;
		if (clear_all) begin
			mid_list_d = 1'b0;
			mid_buf_d  = 1'b0;
			mid_idx_d  = `ADRES_IDX_RST;
			end_list_d = 1'b0;
			end_buf_d  = 1'b0;
			last_idx_d = `ADRES_IDX_RST;
		end else if (any_abort) begin
			// Abort outranks a store seen in the same cycle
			mid_list_d = i_command_list;
			mid_buf_d  = i_result_buffer_list;
			// Stop or wait abort: last stored index, never abort-done
			if (i_abort_hw) begin
				mid_idx_d = last_idx_q;
			end else if (i_abort_conv_busy) begin
				// Store-on-abort keeps the aborted result, so it is newest
				mid_idx_d = ctrl_q[`ADRES_CTRL_STORE_AB]
					? i_abort_index : last_idx_q;
			end
			// Idle abort, waiting on a trigger: index stays put
			if (i_abort_conv_busy & ctrl_q[`ADRES_CTRL_STORE_AB]) begin
				last_idx_d = i_abort_index;
			end
		end else if (i_store_valid) begin
			last_idx_d = i_store_index;
			if (|set_vec) begin
				mid_idx_d = i_store_index;
			end
			if (|set_vec[15:1]) begin
				mid_list_d = i_command_list;
				mid_buf_d  = i_result_buffer_list;
			end
			if (set_vec[0]) begin
				end_list_d = i_command_list;
				end_buf_d  = i_result_buffer_list;
			end
		end
	end

	// Interrupt request from the next flag state, so it tracks the flags
	// Registered, so the request pin comes straight from a flip-flop
	always @* begin
		irq_d = |(conv_flag_d & irq_en_d);
	end

	// State update; the clock enable freezes everything while low
	// Limitation: with the enable low the APB answer stalls as well
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pready_q     <= 1'b0;
			pslverr_q    <= 1'b0;
			prdata_q     <= 32'h0000_0000;
			ctrl_q       <= `ADRES_CTRL_RST;
			irq_en_q     <= `ADRES_FLAGS_RST;
			conv_flag_q  <= `ADRES_FLAGS_RST;
			abort_done_q <= 1'b0;
			overrun_q    <= 1'b0;
			mid_list_q   <= 1'b0;
			mid_buf_q    <= 1'b0;
			mid_idx_q    <= `ADRES_IDX_RST;
			end_list_q   <= 1'b0;
			end_buf_q    <= 1'b0;
			last_idx_q   <= `ADRES_IDX_RST;
			irq_q        <= 1'b0;
		end else if (i_clk_en) begin
			pready_q     <= pready_d;
			pslverr_q    <= pslverr_d;
			prdata_q     <= prdata_d;
			ctrl_q       <= ctrl_d;
			irq_en_q     <= irq_en_d;
			conv_flag_q  <= conv_flag_d;
			abort_done_q <= abort_done_d;
			overrun_q    <= overrun_d;
			mid_list_q   <= mid_list_d;
			mid_buf_q    <= mid_buf_d;
			mid_idx_q    <= mid_idx_d;
			end_list_q   <= end_list_d;
			end_buf_q    <= end_buf_d;
			last_idx_q   <= last_idx_d;
			irq_q        <= irq_d;
		end
	end

	// All outputs straight from flip-flops
	assign o_prdata         = prdata_q;
	assign o_pready         = pready_q;
	assign o_pslverr        = pslverr_q;
	assign o_module_enable  = ctrl_q[`ADRES_CTRL_ENABLE];
	assign o_store_on_abort = ctrl_q[`ADRES_CTRL_STORE_AB];
	assign o_conv_irq       = irq_q;

endmodule // adres_status
